// ==== core/tmr_core.sv ====
// Sixteen-bit timer/counter with capture and two compare channels,
// reached over a simple 8-bit register port with one-cycle reads.
// Assumes bus, vec_ack and glob_irq_en are on clk_sys; pins are not.
// Operation
// R1: With filtering on, capture level changes after four equal samples.
// R2: Edge select zero captures on falling edge, one on rising edge.
// R3: Capture copies counter into capture value and sets capture flag.
// R4: Capture input is ignored when capture value is the TOP source.
// R5: Control B bit five reads zero; software writes zero there.
// R6: Clock select zero stops; codes one to five divide 1..1024.
// R7: Codes six and seven count external falling or rising edges.
// R8: External pin counts even if it is driven as an output.
// R9: All 16-bit registers pass through one shared high-byte latch.
// R10: Counter write blocks compare matches on the next timer tick.
// R11: Compare values are compared continuously; match flags and toggles.
// R12: Capture source is the pin or the analog comparator.
// R13: Request needs enable bit, global enable and flag all set.
// R14: Normal and clear-on-compare set overflow at counter maximum.
// R15: Compare flag sets in timer cycle after counter equals compare.
// R16: A forced compare does not set the compare flag.
// R17: Flags clear on vector execution or on a written one.
// R18: With capture value as TOP, capture flag sets at TOP.
// R19: Wave mode picks count sequence, TOP source and overflow point.
// R20: Forced compare raises no request and clears no counter.
// R21: Counter steps once per tick and holds when clock stopped.
// R22: Reset clears control, mask and flags, so counter is stopped.
`timescale 1ns/10ps
`default_nettype none
module tmr_core
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire tmr_bus_t bus,
  output logic [7:0] rdata,
  input wire logic capture_input_pin,
  input wire logic acomp_in,
  input wire logic ext_clock_pin,
  input wire logic glob_irq_en,
  input wire logic [3:0] vec_ack,
  output logic [3:0] irq_req,
  output logic [1:0] waveform_output
);
  tmr_core_st_t st_r;
  tmr_core_st_t st_nxt;
  logic tick;
  logic cap_lvl;
  logic ext_lvl;
  logic cap_raw;
  logic cap_evt;
  logic match_a;
  logic match_b;
  logic frc_a;
  logic frc_b;
  logic at_top;
  logic [3:0] wave_mode;
  logic [15:0] top;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [7:0] ack_v;
  logic [15:0] rd16;

  ////////////////////////////////////////////////////////////////////
  // Mode decoding helpers

  function automatic logic is_phase(input logic [3:0] m);
    return m inside {WM_PC8, WM_PC9, WM_PC10, WM_PFC_I, WM_PFC_A,
      WM_PC_I, WM_PC_A};
  endfunction

  function automatic logic is_fast(input logic [3:0] m);
    return m inside {WM_FP8, WM_FP9, WM_FP10, WM_FP_I, WM_FP_A};
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    return m inside {WM_PFC_I, WM_PC_I, WM_CTC_I, WM_FP_I};
  endfunction

  // Reserved mode falls back to a full-range count
  function automatic logic [15:0] top_of(input logic [3:0] m,
    input logic [15:0] a, input logic [15:0] c);
    logic [15:0] t;
    t = TOP_MAX;
    if (m inside {WM_PC8, WM_FP8})
      t = TOP_8;
    else if (m inside {WM_PC9, WM_FP9})
      t = TOP_9;
    else if (m inside {WM_PC10, WM_FP10})
      t = TOP_10;
    else if (m inside {WM_CTC_A, WM_PFC_A, WM_PC_A, WM_FP_A})
      t = a;
    else if (cap_is_top(m))
      t = c;
    return t;
  endfunction

  // Sixteen-bit register behind a low-byte index
  function automatic logic [15:0] val16(input logic [3:0] a,
    input tmr_core_st_t s);
    logic [15:0] v;
    v = RST16;
    unique case (a)
      REG_CNT_LO: v = s.cnt;
      REG_CMPA_LO: v = s.cmpa;
      REG_CMPB_LO: v = s.cmpb;
      REG_CAP_LO: v = s.cap;
      default: v = RST16;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Input conditioning and clock source

  // R12: capture source mux ahead of the synchroniser
  assign cap_raw = st_r.ctrl_a[CA_SRC] ? acomp_in : capture_input_pin;

  tmr_in_filter u_cap_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(cap_raw),
    .filt_en(st_r.ctrl_b[CB_FILT]),
    .lvl(cap_lvl)
  );

  // R8: pin level is taken whatever its port direction
  tmr_in_filter u_ext_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(ext_clock_pin),
    .filt_en(1'b0),
    .lvl(ext_lvl)
  );

  tmr_prescaler u_psc (
    .clk_sys(clk_sys),
    .rst(rst),
    .clock_sel(st_r.ctrl_b[2:0]),
    .ext_lvl(ext_lvl),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Event decoding

  // R19: wave mode from both control registers
  assign wave_mode = {st_r.ctrl_b[4:3], st_r.ctrl_a[1:0]};
  assign top = top_of(wave_mode, st_r.cmpa, st_r.cap);
  assign at_top = st_r.cnt == top;

  // R10: blocked compare after a counter write
  // R11: continuous compare, sampled on the timer tick
  assign match_a = tick && !st_r.blk && st_r.cnt == st_r.cmpa;
  assign match_b = tick && !st_r.blk && st_r.cnt == st_r.cmpb;

  // Force strobes act only outside the PWM modes
  assign frc_a = bus.wr && bus.addr == REG_CTRL_A
    && bus.wdata[CA_FRC_A] && !is_phase(wave_mode)
    && !is_fast(wave_mode);
  assign frc_b = bus.wr && bus.addr == REG_CTRL_A
    && bus.wdata[CA_FRC_B] && !is_phase(wave_mode)
    && !is_fast(wave_mode);

  // R2: edge select
  // R4: capture off while capture value is TOP
  assign cap_evt = !cap_is_top(wave_mode)
    && (st_r.ctrl_b[CB_EDGE] ? (cap_lvl && !st_r.cap_prev)
                            : (!cap_lvl && st_r.cap_prev));

  // R17: vector execution clears the matching flag
  assign ack_v = {vec_ack[3], vec_ack[2], vec_ack[1], 1'b0,
    vec_ack[0], 3'h0};

  // Whole 16-bit value behind the index; split into low byte and latch
  assign rd16 = val16(bus.addr, st_r);

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    st_nxt = st_r;
    set_v = RST8;
    clr_v = RST8;
    st_nxt.rdata = RST8;
    st_nxt.cap_prev = cap_lvl;
    // R21: one step per tick, none while stopped
    if (tick)
    begin
      st_nxt.blk = 1'b0;
      if (is_phase(wave_mode))
      begin
        if (!st_r.down)
        begin
          if (st_r.cnt >= top)
          begin
            st_nxt.down = 1'b1;
            st_nxt.cnt = st_r.cnt - CNT_ONE;
            // R18: capture flag at TOP
            set_v[FB_CAP] = cap_is_top(wave_mode);
          end
          else
          begin
            st_nxt.cnt = st_r.cnt + CNT_ONE;
          end
        end
        else if (st_r.cnt == RST16)
        begin
          // R19: dual-slope overflow at bottom
          st_nxt.down = 1'b0;
          st_nxt.cnt = CNT_ONE;
          set_v[FB_OVF] = 1'b1;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      else
      begin
        st_nxt.down = 1'b0;
        // Counter past a lowered TOP runs on to the wrap
        if (at_top || st_r.cnt == TOP_MAX)
          st_nxt.cnt = RST16;
        else
          st_nxt.cnt = st_r.cnt + CNT_ONE;
        // R14: overflow at maximum, fast modes at TOP
        if (is_fast(wave_mode))
          set_v[FB_OVF] = at_top;
        else
          set_v[FB_OVF] = st_r.cnt == TOP_MAX;
        // R18: capture flag at TOP
        if (cap_is_top(wave_mode) && at_top)
          set_v[FB_CAP] = 1'b1;
      end
    end
    // R15: compare flags set after the matching cycle
    // R16: forced compares never set them
    set_v[FB_CMPA] = match_a;
    set_v[FB_CMPB] = match_b;
    // R20: a force only toggles the output
    if (match_a || frc_a)
      st_nxt.wave[0] = ~st_r.wave[0];
    if (match_b || frc_b)
      st_nxt.wave[1] = ~st_r.wave[1];
    // R3: capture copies the counter
    if (cap_evt)
    begin
      st_nxt.cap = st_r.cnt;
      set_v[FB_CAP] = 1'b1;
    end
    // R9: writes go through the shared high-byte latch
    if (bus.wr)
    begin
      case (bus.addr)
        REG_CTRL_A: st_nxt.ctrl_a = bus.wdata & CTRL_A_WMASK;
        // R5: reserved bit never stored
        REG_CTRL_B: st_nxt.ctrl_b = bus.wdata & CTRL_B_WMASK;
        REG_CNT_HI, REG_CMPA_HI, REG_CMPB_HI, REG_CAP_HI:
          st_nxt.temp = bus.wdata;
        REG_CNT_LO:
        begin
          st_nxt.cnt = {st_r.temp, bus.wdata};
          // R10: block the next compare
          st_nxt.blk = 1'b1;
        end
        REG_CMPA_LO: st_nxt.cmpa = {st_r.temp, bus.wdata};
        REG_CMPB_LO: st_nxt.cmpb = {st_r.temp, bus.wdata};
        REG_CAP_LO: st_nxt.cap = {st_r.temp, bus.wdata};
        REG_MASK: st_nxt.mask = bus.wdata & FLAG_USED;
        // R17: written ones clear flags
        REG_FLAGS: clr_v = bus.wdata & FLAG_USED;
        default: st_nxt.temp = st_r.temp;
      endcase
    end
    // R9: low-byte read latches the high byte
    if (bus.rd)
    begin
      case (bus.addr)
        REG_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
        REG_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
        REG_CNT_LO, REG_CMPA_LO, REG_CMPB_LO, REG_CAP_LO:
        begin
          st_nxt.rdata = rd16[7:0];
          st_nxt.temp = rd16[15:8];
        end
        REG_CNT_HI, REG_CMPA_HI, REG_CMPB_HI, REG_CAP_HI:
          st_nxt.rdata = st_r.temp;
        REG_MASK: st_nxt.rdata = st_r.mask;
        REG_FLAGS: st_nxt.rdata = st_r.flags;
        default: st_nxt.rdata = RST8;
      endcase
    end
    // Set wins over a clear in the same cycle
    st_nxt.flags = (st_r.flags & ~clr_v & ~ack_v) | set_v;
  end

  // R22: everything cleared, clock stopped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata = st_r.rdata;
  assign waveform_output = st_r.wave;

  // R13: flag, enable and global enable together
  assign irq_req = {st_r.flags[FB_OVF], st_r.flags[FB_CMPA],
    st_r.flags[FB_CMPB], st_r.flags[FB_CAP]}
    & {st_r.mask[FB_OVF], st_r.mask[FB_CMPA],
    st_r.mask[FB_CMPB], st_r.mask[FB_CAP]} & {4{glob_irq_en}};

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_rsvd_zero;
    (bus.rd && bus.addr == REG_CTRL_B) |=> !rdata[5];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R5
    else $error("reserved control bit read as one");

  property p_capture;
    (cap_evt && !(bus.wr && bus.addr == REG_CAP_LO))
      |=> (st_r.cap == $past(st_r.cnt)) && st_r.flags[FB_CAP];
  endproperty
  a_capture: assert property (p_capture) // R3
    else $error("capture did not copy counter and set flag");

  property p_cap_off;
    cap_is_top(wave_mode) |-> !cap_evt;
  endproperty
  a_cap_off: assert property (p_cap_off) // R4
    else $error("capture taken while capture value is TOP");

  property p_hold;
    (st_r.ctrl_b[2:0] == CS_STOP && !(bus.wr && bus.addr == REG_CNT_LO))
      |=> st_r.cnt == $past(st_r.cnt);
  endproperty
  a_hold: assert property (p_hold) // R21
    else $error("counter moved while stopped");

  property p_block;
    (bus.wr && bus.addr == REG_CNT_LO && !st_r.flags[FB_CMPA]
      && !vec_ack[2]) ##1 (tick && !st_r.flags[FB_CMPA])
      |=> !st_r.flags[FB_CMPA];
  endproperty
  a_block: assert property (p_block) // R10
    else $error("compare flag set on the tick after a counter write");

  property p_cmp_flag;
    (tick && !st_r.blk && st_r.cnt == st_r.cmpa) |=> st_r.flags[FB_CMPA];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) // R15
    else $error("compare A flag not set after match");

  property p_irq;
    irq_req[3] |-> glob_irq_en && st_r.mask[FB_OVF]
      && st_r.flags[FB_OVF];
  endproperty
  a_irq: assert property (p_irq) // R13
    else $error("overflow request without its conditions");

  property p_w1c;
    (bus.wr && bus.addr == REG_FLAGS && bus.wdata[FB_OVF]
      && !set_v[FB_OVF]) |=> !st_r.flags[FB_OVF];
  endproperty
  a_w1c: assert property (p_w1c) // R17
    else $error("overflow flag survived a written one");

  property p_ovf_normal;
    (tick && wave_mode == WM_NORM && st_r.cnt == TOP_MAX)
      |=> st_r.flags[FB_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) // R14
    else $error("overflow flag missed at maximum");

  property p_force;
    (frc_a && !match_a && !st_r.flags[FB_CMPA] && !tick)
      |=> !st_r.flags[FB_CMPA] && st_r.cnt == $past(st_r.cnt);
  endproperty
  a_force: assert property (p_force) // R16
    else $error("forced compare set flag or moved counter");
endmodule // tmr_core
`default_nettype wire

// ==== inc/tmr_pkg.sv ====
// Timer package: register indices, field positions, codes, limits
// and the state records of the timer core and its helpers.
// Assumes an 8-bit register port addressed by a 4-bit index.
`default_nettype none
package tmr_pkg;
  localparam int unsigned FILT_LEN = 4;
  localparam int unsigned PSC_W = 10;
  // Register indices
  localparam logic [3:0] REG_CTRL_A = 4'h0;
  localparam logic [3:0] REG_CTRL_B = 4'h1;
  localparam logic [3:0] REG_CNT_LO = 4'h2;
  localparam logic [3:0] REG_CNT_HI = 4'h3;
  localparam logic [3:0] REG_CMPA_LO = 4'h4;
  localparam logic [3:0] REG_CMPA_HI = 4'h5;
  localparam logic [3:0] REG_CMPB_LO = 4'h6;
  localparam logic [3:0] REG_CMPB_HI = 4'h7;
  localparam logic [3:0] REG_CAP_LO = 4'h8;
  localparam logic [3:0] REG_CAP_HI = 4'h9;
  localparam logic [3:0] REG_MASK = 4'hA;
  localparam logic [3:0] REG_FLAGS = 4'hB;
  // Field positions
  localparam int CA_SRC = 7;
  localparam int CA_FRC_A = 3;
  localparam int CA_FRC_B = 2;
  localparam int CB_FILT = 7;
  localparam int CB_EDGE = 6;
  localparam int FB_OVF = 7;
  localparam int FB_CMPA = 6;
  localparam int FB_CMPB = 5;
  localparam int FB_CAP = 3;
  // Write masks and reset values
  localparam logic [7:0] CTRL_A_WMASK = 8'h83;
  localparam logic [7:0] CTRL_B_WMASK = 8'hDF;
  localparam logic [7:0] FLAG_USED = 8'hE8;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PSC_M8 = 10'h007;
  localparam logic [9:0] PSC_M64 = 10'h03F;
  localparam logic [9:0] PSC_M256 = 10'h0FF;
  localparam logic [9:0] PSC_M1024 = 10'h3FF;
  localparam logic [3:0] FILT_ONES = 4'hF;
  localparam logic [3:0] FILT_ZERO = 4'h0;
  // Fixed TOP values
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // Wave modes
  typedef enum logic [3:0] {
    WM_NORM = 4'h0, WM_PC8 = 4'h1, WM_PC9 = 4'h2, WM_PC10 = 4'h3,
    WM_CTC_A = 4'h4, WM_FP8 = 4'h5, WM_FP9 = 4'h6, WM_FP10 = 4'h7,
    WM_PFC_I = 4'h8, WM_PFC_A = 4'h9, WM_PC_I = 4'hA, WM_PC_A = 4'hB,
    WM_CTC_I = 4'hC, WM_RSVD = 4'hD, WM_FP_I = 4'hE, WM_FP_A = 4'hF
  } tmr_wave_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr_bus_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic [FILT_LEN-1:0] hist;
    logic out;
  } tmr_filt_st_t;
  typedef struct packed {
    logic [PSC_W-1:0] div;
    logic ext_prev;
  } tmr_psc_st_t;
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic blk;
    logic down;
    logic cap_prev;
    logic [1:0] wave;
  } tmr_core_st_t;
endpackage
`default_nettype wire

// ==== core/tmr_in_filter.sv ====
// Two-stage synchroniser with an optional four-sample majority-free
// filter. Assumes raw comes from a pin outside the clk_sys domain.
`timescale 1ns/10ps
`default_nettype none
module tmr_in_filter
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic raw,
  input wire logic filt_en,
  output logic lvl
);
  tmr_filt_st_t st_r;
  tmr_filt_st_t st_nxt;

  // Sync chain, sample history and filtered level
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.hist = {st_r.hist[FILT_LEN-2:0], st_r.s2};
    if (!filt_en)
    begin
      st_nxt.out = st_r.s2;
    end
    // R1: four equal samples
    // Registered history gives the full four-cycle extra delay
    else if (st_r.hist == FILT_ONES)
    begin
      st_nxt.out = 1'b1;
    end
    else if (st_r.hist == FILT_ZERO)
    begin
      st_nxt.out = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign lvl = st_r.out;

  property p_filt_change;
    @(posedge clk_sys) disable iff (rst)
    ($past(filt_en) && filt_en && st_r.out != $past(st_r.out))
      |-> (st_r.out ? $past(st_r.hist) == FILT_ONES
                    : $past(st_r.hist) == FILT_ZERO);
  endproperty
  a_filt_change: assert property (p_filt_change) // R1
    else $error("filtered level changed without four equal samples");
endmodule // tmr_in_filter
`default_nettype wire

// ==== core/tmr_prescaler.sv ====
// Free-running prescaler and external clock edge picker; gives one
// tick pulse per counter step. Assumes ext_lvl is already synced.
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] clock_sel,
  input wire logic ext_lvl,
  output logic tick
);
  tmr_psc_st_t st_r;
  tmr_psc_st_t st_nxt;

  // Divider never resets on a select change; first tick may be short
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + 10'h001;
    st_nxt.ext_prev = ext_lvl;
  end

  // R6: divided and stopped rates
  // R7: external edge select
  always_comb
  begin
    unique case (clock_sel)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (st_r.div & PSC_M8) == PSC_M8;
      CS_DIV64: tick = (st_r.div & PSC_M64) == PSC_M64;
      CS_DIV256: tick = (st_r.div & PSC_M256) == PSC_M256;
      CS_DIV1024: tick = st_r.div == PSC_M1024;
      CS_EXT_FALL: tick = st_r.ext_prev & ~ext_lvl;
      CS_EXT_RISE: tick = ~st_r.ext_prev & ext_lvl;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  property p_stop;
    @(posedge clk_sys) disable iff (rst)
    (clock_sel == CS_STOP) |-> !tick;
  endproperty
  a_stop: assert property (p_stop) // R6
    else $error("tick while clock stopped");

  property p_ext_rise;
    @(posedge clk_sys) disable iff (rst)
    (clock_sel == CS_EXT_RISE && $past(clock_sel) == CS_EXT_RISE
      && $rose(ext_lvl)) |-> tick;
  endproperty
  a_ext_rise: assert property (p_ext_rise) // R7
    else $error("rising external edge gave no tick");
endmodule // tmr_prescaler
`default_nettype wire

// ==== testbench/tmr_core_bench.sv ====
// Self-checking bench for the timer core: drives the register port,
// capture, comparator and external clock pins and checks the answers.
// Assumes the tmr_pkg register map and one-cycle registered read data.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) \
  begin \
    tests_run++; \
    if ((s) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch %s exp %h seen %h", nm, e, s); \
    end \
  end
module tmr_core_bench;
  import tmr_pkg::*;
  logic clk_sys, rst, capture_input_pin, acomp_in, ext_clock_pin;
  logic glob_irq_en;
  tmr_bus_t bus;
  logic [3:0] vec_ack, irq_req;
  logic [7:0] rdata, d;
  logic [1:0] waveform_output, w0;
  logic [15:0] v, c0, c1;
  int n_mismatch = 0;
  int tests_run = 0;
  int dv[6] = '{0, 1, 8, 64, 256, 1024};

  tmr_core i_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .capture_input_pin(capture_input_pin), .acomp_in(acomp_in),
    .ext_clock_pin(ext_clock_pin), .glob_irq_en(glob_irq_en),
    .vec_ack(vec_ack), .irq_req(irq_req),
    .waveform_output(waveform_output));

  ////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Write strobe for one cycle, then an idle cycle so no strobe sticks
  task wr(input logic [3:0] a, input logic [7:0] x);
    bus <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask

  // Read data stands one cycle only; sampled mid-cycle to dodge races
  task rd(input logic [3:0] a, output logic [7:0] x);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(negedge clk_sys);
    x = rdata;
    @(posedge clk_sys);
  endtask

  task ck(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] x;
    rd(a, x);
    `CHK($sformatf("reg %h", a), e, x)
  endtask

  // High byte goes to the shared latch first, low byte commits
  task w16(input logic [3:0] a, input logic [15:0] x);
    wr(a + 4'h1, x[15:8]);
    wr(a, x[7:0]);
  endtask

  task r16(input logic [3:0] a, output logic [15:0] x);
    rd(a, x[7:0]);
    rd(a + 4'h1, x[15:8]);
  endtask

  task cp(input logic l);
    capture_input_pin <= l;
    cyc(12);
  endtask

  task ex(input logic l, input logic [15:0] e);
    ext_clock_pin <= l;
    cyc(8);
    r16(REG_CNT_LO, v);
    `CHK("ext count", e, v)
  endtask

  // Same schedule each run, so only the filter delay differs
  task capt_run(input logic [7:0] cb, output logic [15:0] c);
    w16(REG_CNT_LO, 16'h0000);
    wr(REG_CTRL_B, cb);
    cyc(20);
    cp(1'b1);
    cyc(20);
    cp(1'b0);
    wr(REG_CTRL_B, 8'h00);
    r16(REG_CAP_LO, c);
    wr(REG_FLAGS, 8'hE8);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 20000 cycles
  initial
  begin
    cyc(20000);
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    rst = 1'b1;
    bus = '0;
    {capture_input_pin, acomp_in, ext_clock_pin, glob_irq_en} = 4'h0;
    vec_ack = 4'h0;
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    // Reset values, unmapped index included
    for (int i = 0; i < 16; i++) ck(4'(i), 8'h00);
    `CHK("irq", 4'h0, irq_req)
    wr(REG_CTRL_B, 8'h20);
    ck(REG_CTRL_B, 8'h00);
    wr(4'hC, 8'hFF);
    ck(4'hC, 8'h00);
    wr(REG_FLAGS, 8'hFF);
    ck(REG_FLAGS, 8'h00);
    // Shared high-byte latch
    w16(REG_CNT_LO, 16'h1234);
    r16(REG_CNT_LO, v);
    `CHK("cnt", 16'h1234, v)
    rd(REG_CNT_LO, d);
    ck(REG_CMPA_HI, 8'h12);
    wr(REG_CMPA_HI, 8'hAB);
    wr(REG_CMPB_LO, 8'hCD);
    r16(REG_CMPB_LO, v);
    `CHK("cmpb", 16'hABCD, v)
    // Prescaler codes: about four ticks in four divided periods
    for (int i = 1; i < 6; i++)
    begin
      w16(REG_CNT_LO, 16'h0000);
      wr(REG_CTRL_B, 8'(i));
      cyc(4 * dv[i] - 1);
      wr(REG_CTRL_B, 8'h00);
      r16(REG_CNT_LO, v);
      `CHK("div", 1'b1, v >= 16'h0003 && v <= 16'h0006)
    end
    cyc(20);
    r16(REG_CNT_LO, c0);
    `CHK("hold", v, c0)
    // External clock edges
    w16(REG_CNT_LO, 16'h0000);
    wr(REG_CTRL_B, 8'h06);
    ex(1'b1, 16'h0000);
    ex(1'b0, 16'h0001);
    wr(REG_CTRL_B, 8'h07);
    ex(1'b1, 16'h0002);
    ex(1'b0, 16'h0002);
    wr(REG_CTRL_B, 8'h00);
    // Capture edges with a stopped counter
    w16(REG_CNT_LO, 16'h0555);
    cp(1'b1);
    ck(REG_FLAGS, 8'h00);
    cp(1'b0);
    ck(REG_FLAGS, 8'h08);
    r16(REG_CAP_LO, v);
    `CHK("cap", 16'h0555, v)
    wr(REG_FLAGS, 8'h08);
    ck(REG_FLAGS, 8'h00);
    wr(REG_CTRL_B, 8'h40);
    w16(REG_CNT_LO, 16'h0777);
    cp(1'b1);
    r16(REG_CAP_LO, v);
    `CHK("cap", 16'h0777, v)
    wr(REG_FLAGS, 8'h08);
    cp(1'b0);
    ck(REG_FLAGS, 8'h00);
    // Filter: short glitch dropped, then four cycles of extra delay
    wr(REG_CTRL_B, 8'hC0);
    capture_input_pin <= 1'b1;
    cyc(2);
    cp(1'b0);
    ck(REG_FLAGS, 8'h00);
    capt_run(8'h41, c0);
    capt_run(8'hC1, c1);
    `CHK("filt", 16'h0004, c1 - c0)
    // Comparator as capture source
    wr(REG_CTRL_A, 8'h80);
    wr(REG_CTRL_B, 8'h00);
    acomp_in <= 1'b1;
    cyc(12);
    acomp_in <= 1'b0;
    cyc(12);
    ck(REG_FLAGS, 8'h08);
    wr(REG_FLAGS, 8'h08);
    wr(REG_CTRL_A, 8'h00);
    // Capture value as TOP: pin ignored, flag at TOP
    w16(REG_CAP_LO, 16'h0100);
    wr(REG_CTRL_B, 8'h18);
    cp(1'b1);
    cp(1'b0);
    ck(REG_FLAGS, 8'h00);
    r16(REG_CAP_LO, v);
    `CHK("cap", 16'h0100, v)
    w16(REG_CNT_LO, 16'h0000);
    wr(REG_CTRL_B, 8'h19);
    cyc(300);
    wr(REG_CTRL_B, 8'h00);
    rd(REG_FLAGS, d);
    `CHK("captop", 1'b1, d[FB_CAP])
    wr(REG_FLAGS, 8'hE8);
    // Compare matches, requests and clears
    w16(REG_CMPA_LO, 16'h0010);
    w16(REG_CMPB_LO, 16'h0020);
    w16(REG_CNT_LO, 16'h0000);
    w0 = waveform_output;
    wr(REG_CTRL_B, 8'h01);
    cyc(50);
    wr(REG_CTRL_B, 8'h00);
    ck(REG_FLAGS, 8'h60);
    `CHK("wave", ~w0, waveform_output)
    wr(REG_MASK, 8'h60);
    `CHK("irq", 4'h0, irq_req)
    glob_irq_en <= 1'b1;
    cyc(2);
    `CHK("irq", 4'h6, irq_req)
    vec_ack <= 4'h4;
    cyc(1);
    vec_ack <= 4'h0;
    cyc(2);
    `CHK("irq", 4'h2, irq_req)
    wr(REG_FLAGS, 8'h20);
    ck(REG_FLAGS, 8'h00);
    // Forced compare toggles output only
    w0 = waveform_output;
    wr(REG_CTRL_A, 8'h0C);
    ck(REG_FLAGS, 8'h00);
    `CHK("irq", 4'h0, irq_req)
    `CHK("wave", ~w0, waveform_output)
    // Counter write hides the match on the next tick
    w16(REG_CNT_LO, 16'h0010);
    wr(REG_CTRL_B, 8'h01);
    cyc(4);
    wr(REG_CTRL_B, 8'h00);
    ck(REG_FLAGS, 8'h00);
    // Overflow in normal mode
    wr(REG_MASK, 8'h80);
    w16(REG_CNT_LO, 16'hFFF0);
    wr(REG_CTRL_B, 8'h01);
    cyc(30);
    wr(REG_CTRL_B, 8'h00);
    rd(REG_FLAGS, d);
    `CHK("ovf", 1'b1, d[FB_OVF])
    `CHK("irq", 1'b1, irq_req[3])
    stop_test;
  end
endmodule // tmr_core_bench
`default_nettype wire
